//--- verilog/masp_pkg.sv
// masp_pkg: register indexes, field layouts, reset values and link constants
// assumes a 32-bit wishbone slave, byte address = 4 * register index
// Function
// - each slot address is {high word, middle word, low word}, high word on top.
// - low word holds bytes one and two, middle three and four, high five and six.
// - config bit 15 enables polling; bits 12:8 give the polled phy address.
// - poll timer expires every 160 * 2^(16 - divider) host clocks.
// - sampled phy status is a 16-bit read-only register; writes ignored.
// - a fixed 16-bit identifier register is read-only, unaffected by writes.
package masp_pkg;

  // register indexes as printed; byte address is four times these
  localparam logic [7:0] IDX_SLOT1_LOW = 8'h70;
  localparam logic [7:0] IDX_SLOT1_MID = 8'h72;
  localparam logic [7:0] IDX_SLOT1_HIGH = 8'h74;
  localparam logic [7:0] IDX_SLOT2_LOW = 8'h78;
  localparam logic [7:0] IDX_SLOT2_MID = 8'h7a;
  localparam logic [7:0] IDX_SLOT2_HIGH = 8'h7c;
  localparam logic [7:0] IDX_SLOT3_LOW = 8'h80;
  localparam logic [7:0] IDX_SLOT3_MID = 8'h82;
  localparam logic [7:0] IDX_SLOT3_HIGH = 8'h84;
  localparam logic [7:0] IDX_POLL_CONFIG = 8'h88;
  localparam logic [7:0] IDX_PHY_STATUS = 8'h8a;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h8c;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h8e;
  localparam logic [7:0] IDX_MAC_IDENT = 8'hbe;

  // poll config fields
  localparam int CFG_EN_BIT = 15;
  localparam int CFG_PHY_MGMT_ADDRESS_LSB = 8;
  localparam int CFG_PHY_MGMT_ADDRESS_W = 5;
  localparam int CFG_DIV_LSB = 0;
  localparam int CFG_DIV_W = 3;
  localparam logic [15:0] CFG_WRITABLE = 16'h9f07;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // interrupt status / mask layout
  localparam int IRQ_W = 3;
  localparam int IRQ_POLL_DONE = 0;
  localparam int IRQ_STATUS_CHANGED = 1;
  localparam int IRQ_POLL_OVERRUN = 2;

  // poll timer: base multiplier and exponent top
  localparam int POLL_BASE_CYCLES = 160;
  localparam int POLL_EXP_TOP = 16;

  // management frame: status register number and field widths
  localparam logic [4:0] PHY_STATUS_REG = 5'h01;
  localparam int MGMT_HEAD_BITS = 46;
  localparam int MGMT_DATA_FIRST = 48;
  localparam int MGMT_LAST_BIT = 63;
  localparam logic [31:0] MGMT_PREAMBLE = 32'hffff_ffff;
  localparam logic [3:0] MGMT_START_READ = 4'h6;
  localparam int MGMT_HALF_DEFAULT = 8;

  typedef enum logic [1:0] {
    MASP_ACC_NONE,
    MASP_ACC_READ,
    MASP_ACC_WRITE
  } masp_acc_t;

endpackage

//--- verilog/masp_mgmt_read.sv
// masp_mgmt_read: one management read frame to a phy register
// assumes synced reset from the top; mdio pin is raw and synchronised here
`timescale 1ns/10ps
module masp_mgmt_read #(
  parameter int HALF_CYCLES = masp_pkg::MGMT_HALF_DEFAULT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request
  input wire logic start,
  input wire logic [4:0] phy_addr,
  input wire logic [4:0] reg_addr,
  output logic busy,
  output logic done,
  output logic [15:0] rd_data,
  // management pins
  output logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_n
);
  import masp_pkg::*;

  // the sample needs the two sync stages to settle within a half period
  initial begin
    if (HALF_CYCLES < 4) $error("HALF_CYCLES must be at least 4");
  end

  logic mdio_meta;
  logic mdio_sync;
  logic [15:0] half_cnt;
  logic [5:0] bit_idx;
  logic [MGMT_HEAD_BITS-1:0] frame;

  // pin synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mdio_meta <= 1'b0;
      mdio_sync <= 1'b0;
    end else begin
      mdio_meta <= mdio_i;
      mdio_sync <= mdio_meta;
    end
  end

  assign mdio_o = frame[MGMT_HEAD_BITS-1];

  // frame sequencer: drive on mdc fall, sample on mdc rise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      mdc <= 1'b0;
      mdio_oe_n <= 1'b1;
      half_cnt <= 16'h0000;
      bit_idx <= 6'h00;
      frame <= '0;
      rd_data <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        if (start) begin
          busy <= 1'b1;
          mdc <= 1'b0;
          mdio_oe_n <= 1'b0;
          half_cnt <= 16'h0000;
          bit_idx <= 6'h00;
          frame <= {MGMT_PREAMBLE, MGMT_START_READ, phy_addr, reg_addr};
        end
      end else if (half_cnt == 16'(HALF_CYCLES - 1)) begin
        half_cnt <= 16'h0000;
        if (!mdc) begin
          mdc <= 1'b1;
          if (bit_idx >= 6'(MGMT_DATA_FIRST)) begin
            rd_data <= {rd_data[14:0], mdio_sync};
          end
          if (bit_idx == 6'(MGMT_LAST_BIT)) begin
            busy <= 1'b0;
            done <= 1'b1;
          end
        end else begin
          mdc <= 1'b0;
          bit_idx <= bit_idx + 6'h01;
          frame <= {frame[MGMT_HEAD_BITS-2:0], 1'b1};
          // release the line for turnaround and data
          if (bit_idx >= 6'(MGMT_HEAD_BITS - 1)) mdio_oe_n <= 1'b1;
        end
      end else begin
        half_cnt <= half_cnt + 16'h0001;
      end
    end
  end

endmodule // masp_mgmt_read

//--- verilog/masp_top.sv
// masp_top: extra address slots, phy status poll and identifier registers
// assumes a classic wishbone master on mclk and one phy on the mgmt pins
`timescale 1ns/10ps
module masp_top #(
  parameter int POLL_BASE = masp_pkg::POLL_BASE_CYCLES,
  parameter int POLL_EXP = masp_pkg::POLL_EXP_TOP,
  parameter int MGMT_HALF = masp_pkg::MGMT_HALF_DEFAULT,
  parameter logic [15:0] MAC_IDENT = 16'h5a5a // arbitrary value
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // interrupt
  output logic irq,
  // assembled slot addresses
  output logic [47:0] addr_slot1,
  output logic [47:0] addr_slot2,
  output logic [47:0] addr_slot3,
  // phy management pins
  output logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_n
);
  import masp_pkg::*;

  // the divider field reaches 7, so the exponent must cover it
  initial begin
    if (POLL_EXP < 7 || POLL_EXP > 16) $error("POLL_EXP must be 7 to 16");
    if (POLL_BASE < 1 || POLL_BASE > 65535) $error("POLL_BASE out of range");
  end

  logic rst_meta;
  logic rst_sync_n;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  logic [7:0] idx;
  logic req;
  logic hit_slot;
  logic [3:0] slot_sel;
  logic hit_cfg;
  logic hit_status;
  logic hit_irq_st;
  logic hit_irq_mask;
  logic hit_ident;
  masp_acc_t acc;

  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i && wb_stb_i;

  // slot words map to entries 0..8: low, mid, high per slot
  always_comb begin
    hit_slot = 1'b1;
    slot_sel = 4'h0;
    if (idx == IDX_SLOT1_LOW) slot_sel = 4'h0;
    else if (idx == IDX_SLOT1_MID) slot_sel = 4'h1;
    else if (idx == IDX_SLOT1_HIGH) slot_sel = 4'h2;
    else if (idx == IDX_SLOT2_LOW) slot_sel = 4'h3;
    else if (idx == IDX_SLOT2_MID) slot_sel = 4'h4;
    else if (idx == IDX_SLOT2_HIGH) slot_sel = 4'h5;
    else if (idx == IDX_SLOT3_LOW) slot_sel = 4'h6;
    else if (idx == IDX_SLOT3_MID) slot_sel = 4'h7;
    else if (idx == IDX_SLOT3_HIGH) slot_sel = 4'h8;
    else hit_slot = 1'b0;
  end

  assign hit_cfg = idx == IDX_POLL_CONFIG;
  assign hit_status = idx == IDX_PHY_STATUS;
  assign hit_irq_st = idx == IDX_IRQ_STATUS;
  assign hit_irq_mask = idx == IDX_IRQ_MASK;
  assign hit_ident = idx == IDX_MAC_IDENT;

  // the access commits on the edge where the master sees ack high
  always_comb begin
    acc = MASP_ACC_NONE;
    if (req && wb_ack_o) begin
      if (wb_we_i) acc = MASP_ACC_WRITE;
      else acc = MASP_ACC_READ;
    end
  end

  // byte-lane merge of a 16-bit register with the write data
  function automatic logic [15:0] lane_merge(input logic [15:0] old_val,
                                             input logic [31:0] data,
                                             input logic [3:0] sel);
    logic [15:0] res;
    res = old_val;
    if (sel[0]) res[7:0] = data[7:0];
    if (sel[1]) res[15:8] = data[15:8];
    return res;
  endfunction

  // ------------------------------------------------------------
  // address slot words
  // ------------------------------------------------------------
  logic [15:0] slot_word [9];
  logic [47:0] slot_addr [3];

  // each word is its own register; a write hits one entry only
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int i = 0; i < 9; i++) slot_word[i] <= WORD_RESET;
    end else if (acc == MASP_ACC_WRITE && hit_slot) begin
      slot_word[slot_sel] <= lane_merge(slot_word[slot_sel], wb_dat_i, wb_sel_i);
    end
  end

  // first bytes sit in the low word, last bytes in the high word
  for (genvar s = 0; s < 3; s++) begin : g_slot
    assign slot_addr[s] = {slot_word[3*s+2], slot_word[3*s+1], slot_word[3*s]};
  end

  assign addr_slot1 = slot_addr[0];
  assign addr_slot2 = slot_addr[1];
  assign addr_slot3 = slot_addr[2];

  // ------------------------------------------------------------
  // poll configuration
  // ------------------------------------------------------------
  logic [15:0] poll_cfg;
  logic poll_en;
  logic [4:0] phy_mgmt_address;
  logic [2:0] poll_timer_divider;

  // reserved bits never store, so they always read zero
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      poll_cfg <= CFG_RESET;
    end else if (acc == MASP_ACC_WRITE && hit_cfg) begin
      poll_cfg <= lane_merge(poll_cfg, wb_dat_i, wb_sel_i) & CFG_WRITABLE;
    end
  end

  assign poll_en = poll_cfg[CFG_EN_BIT];
  assign phy_mgmt_address = poll_cfg[CFG_PHY_MGMT_ADDRESS_LSB +: CFG_PHY_MGMT_ADDRESS_W];
  assign poll_timer_divider = poll_cfg[CFG_DIV_LSB +: CFG_DIV_W];

  // ------------------------------------------------------------
  // poll timer
  // ------------------------------------------------------------
  logic [15:0] base_cnt;
  logic [16:0] exp_cnt;
  logic [16:0] exp_limit;
  logic base_wrap;
  logic poll_tick;

  // a divider change takes effect on the next wrap of the counter
  assign exp_limit = (17'h0_0001 << (5'(POLL_EXP) - {2'b00, poll_timer_divider}))
                     - 17'h0_0001;
  assign base_wrap = base_cnt == 16'(POLL_BASE - 1);
  assign poll_tick = base_wrap && exp_cnt >= exp_limit;

  // counters hold at zero while disabled so enable starts a full period
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      base_cnt <= 16'h0000;
      exp_cnt <= 17'h0_0000;
    end else if (!poll_en) begin
      base_cnt <= 16'h0000;
      exp_cnt <= 17'h0_0000;
    end else if (base_wrap) begin
      base_cnt <= 16'h0000;
      if (poll_tick) exp_cnt <= 17'h0_0000;
      else exp_cnt <= exp_cnt + 17'h0_0001;
    end else begin
      base_cnt <= base_cnt + 16'h0001;
    end
  end

  // ------------------------------------------------------------
  // management read of the phy status
  // ------------------------------------------------------------
  logic mgmt_start;
  logic mgmt_busy;
  logic mgmt_done;
  logic [15:0] mgmt_data;
  logic poll_overrun;

  // a tick during a running frame is dropped and flagged instead
  assign mgmt_start = poll_en && poll_tick && !mgmt_busy;
  assign poll_overrun = poll_en && poll_tick && mgmt_busy;

  masp_mgmt_read #(
    .HALF_CYCLES(MGMT_HALF)
  ) u_mgmt (
    .clk(mclk),
    .rst_n(rst_sync_n),
    .start(mgmt_start),
    .phy_addr(phy_mgmt_address),
    .reg_addr(PHY_STATUS_REG),
    .busy(mgmt_busy),
    .done(mgmt_done),
    .rd_data(mgmt_data),
    .mdc(mdc),
    .mdio_i(mdio_i),
    .mdio_o(mdio_o),
    .mdio_oe_n(mdio_oe_n)
  );

  logic [15:0] phy_status;
  logic status_changed;

  assign status_changed = mgmt_done && mgmt_data != phy_status;

  // only a finished frame updates it; the bus has no write path here
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phy_status <= WORD_RESET;
    end else if (mgmt_done) begin
      phy_status <= mgmt_data;
    end
  end

  // ------------------------------------------------------------
  // interrupt status and mask
  // ------------------------------------------------------------
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic irq_rd_clear;

  always_comb begin
    irq_events = '0;
    irq_events[IRQ_POLL_DONE] = mgmt_done;
    irq_events[IRQ_STATUS_CHANGED] = status_changed;
    irq_events[IRQ_POLL_OVERRUN] = poll_overrun;
  end

  assign irq_rd_clear = acc == MASP_ACC_READ && hit_irq_st;

  // a read clears only the bits it returned: read data is latched a cycle before
  // the ack edge, so a bit set in between must survive; same-cycle events win too
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_status <= '0;
    end else if (irq_rd_clear) begin
      irq_status <= (irq_status & ~wb_dat_o[IRQ_W-1:0]) | irq_events;
    end else begin
      irq_status <= irq_status | irq_events;
    end
  end

  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_mask <= '0;
    end else if (acc == MASP_ACC_WRITE && hit_irq_mask && wb_sel_i[0]) begin
      irq_mask <= wb_dat_i[IRQ_W-1:0];
    end
  end

  // level output, drops once the status read clears the bits
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status & irq_mask);
    end
  end

  // ------------------------------------------------------------
  // read mux and ack
  // ------------------------------------------------------------
  logic [15:0] next_rd_word;

  // unmapped indexes answer with zero; identifier ignores writes
  always_comb begin
    next_rd_word = 16'h0000;
    if (hit_slot) next_rd_word = slot_word[slot_sel];
    else if (hit_cfg) next_rd_word = poll_cfg;
    else if (hit_status) next_rd_word = phy_status;
    else if (hit_irq_st) next_rd_word = 16'(irq_status);
    else if (hit_irq_mask) next_rd_word = 16'(irq_mask);
    else if (hit_ident) next_rd_word = MAC_IDENT;
  end

  // one-cycle ack after the request; data latched with it
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
      if (req && !wb_ack_o && !wb_we_i) begin
        wb_dat_o <= {16'h0000, next_rd_word};
      end
    end
  end

endmodule // masp_top

//--- verification/masp_properties.sv
// masp_properties: port-level checks for masp_top
// assumes MGMT_HALF = 4 and config written with both low lanes
`timescale 1ns/10ps
module masp_properties
  import masp_pkg::*;
#(
  parameter int MGMT_HALF = 4,
  parameter logic [15:0] MAC_IDENT = 16'h0000
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // slots and management pins
  input wire logic [47:0] addr_slot1,
  input wire logic [47:0] addr_slot2,
  input wire logic [47:0] addr_slot3,
  input wire logic mdc,
  input wire logic mdio_o,
  input wire logic mdio_oe_n
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // completed accesses
  logic wr_ack;
  logic rd_ack;
  logic [7:0] idx;
  assign idx = wb_adr_i[9:2];
  assign wr_ack = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[1:0] == 2'b11;
  assign rd_ack = wb_cyc_i && wb_stb_i && wb_ack_o && !wb_we_i;
  // cycle index in a frame, saturating so it never wraps into a fake frame
  logic [11:0] fc;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fc <= 12'h000;
    end else if ($fell(mdio_oe_n)) begin
      fc <= 12'h001;
    end else if (fc != 12'h000 && fc != 12'hfff) begin
      fc <= fc + 12'h001;
    end
  end
  // config frozen at frame start, so a write mid-frame does not confuse the check
  logic [15:0] cfg;
  logic [15:0] fcfg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg <= 16'h0000;
      fcfg <= 16'h0000;
    end else begin
      if (wr_ack && idx == IDX_POLL_CONFIG) cfg <= wb_dat_i[15:0];
      // the frame took its address one edge earlier, before a write on that edge
      if ($fell(mdio_oe_n)) fcfg <= $past(cfg);
    end
  end
  logic [13:0] hd;
  int unsigned bi;
  logic mid;
  assign hd = {MGMT_START_READ, fcfg[12:8], PHY_STATUS_REG};
  assign bi = fc / (2 * MGMT_HALF);
  assign mid = (fc % (2 * MGMT_HALF)) == MGMT_HALF;
  sequence seq_half;
    $stable(mdc) [*3] ##1 $changed(mdc);
  endsequence

  a_slot_high_top: assert property (
    wr_ack && idx == IDX_SLOT1_HIGH |=> addr_slot1[47:32] == $past(wb_dat_i[15:0]))
    else $error("slot1 high word misplaced");
  a_slot_low_first: assert property (
    wr_ack && idx == IDX_SLOT2_LOW |=> addr_slot2[15:0] == $past(wb_dat_i[15:0]))
    else $error("slot2 low word misplaced");
  a_slot_mid_word: assert property (
    wr_ack && idx == IDX_SLOT3_MID |=> addr_slot3[31:16] == $past(wb_dat_i[15:0]))
    else $error("slot3 mid word misplaced");
  a_ident_read_fixed: assert property (
    rd_ack && idx == IDX_MAC_IDENT |-> wb_dat_o == {16'h0000, MAC_IDENT})
    else $error("identifier read wrong");
  a_preamble_ones: assert property (
    fc != 12'h000 && fc < 12'(64 * MGMT_HALF) |-> !mdio_oe_n && mdio_o)
    else $error("preamble not all ones");
  a_frame_head: assert property (
    bi >= 32 && bi <= 45 && mid |-> mdio_o == hd[45 - bi])
    else $error("frame head bit wrong");
  a_mdc_half_period: assert property (
    !mdio_oe_n && $changed(mdc) |=> seq_half)
    else $error("mdc half period wrong");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule // masp_properties

bind masp_top masp_properties #(.MGMT_HALF(MGMT_HALF), .MAC_IDENT(MAC_IDENT)) chk_u (
  .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .addr_slot1(addr_slot1),
  .addr_slot2(addr_slot2), .addr_slot3(addr_slot3), .mdc(mdc), .mdio_o(mdio_o),
  .mdio_oe_n(mdio_oe_n));

//--- verification/masp_phy_model.sv
// masp_phy_model: phy answering status reads at one management address
// assumes the bench resolves the pin with a pull-up from both enables
`timescale 1ns/10ps
module masp_phy_model
  import masp_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = 5'h0b
) (
  // management pins
  input wire logic mdc,
  input wire logic mdio,
  input wire logic host_oe_n,
  // answer side
  input wire logic [15:0] status,
  output logic drive_oe,
  output logic drive_bit,
  output logic [45:0] head
);
  int cnt = 64;
  // shift in the head; a frame starts on the first rise with the host driving
  always @(posedge mdc) begin
    if (cnt >= 64 && !host_oe_n) cnt = 0;
    if (cnt < 46) head = {head[44:0], mdio};
    cnt = cnt + 1;
    if (cnt >= 64) drive_oe = 1'b0;
  end
  // answer only a status read to our own address, else the pull-up shows
  always @(negedge mdc) begin
    if (cnt >= 47 && cnt <= 63 && head[13:0] == {MGMT_START_READ, PHY_ADDR, PHY_STATUS_REG}) begin
      drive_oe = 1'b1;
      drive_bit = (cnt == 47) ? 1'b0 : status[63 - cnt];
    end
  end
  initial drive_oe = 1'b0;
  initial drive_bit = 1'b0;
endmodule // masp_phy_model

//--- verification/testbench.sv
// testbench: register and poll scenarios for masp_top
// assumes the bench phy model and a pull-up on the management data pin
`timescale 1ns/10ps
module testbench;
  import masp_pkg::*;
  localparam logic [15:0] IDENT = 16'h3c3c; // arbitrary value
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, irq, mdc, mdio_o, mdio_oe_n, phy_oe, phy_bit;
  wire mdio_i;
  logic [47:0] slot [3];
  logic [45:0] head;
  logic [15:0] q;
  int fails = 0;
  int tests_run = 0;
  int gap;
  logic [7:0] regs [14] = '{IDX_SLOT1_LOW, IDX_SLOT1_MID, IDX_SLOT1_HIGH, IDX_SLOT2_LOW,
    IDX_SLOT2_MID, IDX_SLOT2_HIGH, IDX_SLOT3_LOW, IDX_SLOT3_MID, IDX_SLOT3_HIGH,
    IDX_POLL_CONFIG, IDX_PHY_STATUS, IDX_IRQ_STATUS, IDX_IRQ_MASK, IDX_MAC_IDENT};
  // clock, and the pin with its pull-up
  always #12.5 mclk = ~mclk;
  assign mdio_i = !mdio_oe_n ? mdio_o : (phy_oe ? phy_bit : 1'b1);
  masp_top #(.POLL_BASE(4), .POLL_EXP(9), .MGMT_HALF(4), .MAC_IDENT(IDENT)) dut_u (
    .mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .addr_slot1(slot[0]),
    .addr_slot2(slot[1]), .addr_slot3(slot[2]), .mdc(mdc), .mdio_i(mdio_i),
    .mdio_o(mdio_o), .mdio_oe_n(mdio_oe_n));
  masp_phy_model #(.PHY_ADDR(5'h0b)) phy_u (.mdc(mdc), .mdio(mdio_i),
    .host_oe_n(mdio_oe_n), .status(16'hc35a), .drive_oe(phy_oe), .drive_bit(phy_bit),
    .head(head));
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one classic cycle, held until ack, then one idle cycle
  task automatic wb(input logic we, input logic [7:0] idx, input logic [15:0] d,
                    input logic [3:0] sel);
    int n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= {16'h0000, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge mclk);
    if (n >= 20) check("ack timeout", 48'h1, 48'h0);
    if (n >= 20) finish_test();
  endtask
  // bounded waits: an irq, or the next frame start
  task automatic wait_irq;
    int n = 0;
    while (irq !== 1'b1 && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 5000) check("irq timeout", 48'h1, 48'h0);
    if (n >= 5000) finish_test();
  endtask
  task automatic frame_gap(output int n);
    n = 0;
    while (mdio_oe_n !== 1'b1 && n < 9000) begin
      @(posedge mclk);
      n++;
    end
    while (mdio_oe_n !== 1'b0 && n < 9000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 9000) check("frame timeout", 48'h1, 48'h0);
    if (n >= 9000) finish_test();
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    foreach (regs[i]) begin
      wb(1'b0, regs[i], 16'h0000, 4'hf);
      check("reset", q, (regs[i] == IDX_MAC_IDENT) ? IDENT : 16'h0000);
    end
    // slot s holds bytes 16s+1 .. 16s+6, first byte lowest
    for (int s = 0; s < 3; s++) begin
      for (int w = 0; w < 3; w++) begin
        wb(1'b1, regs[3*s+w], {8'(16*s+2*w+2), 8'(16*s+2*w+1)}, 4'hf);
        wb(1'b0, regs[3*s+w], 16'h0000, 4'hf);
        check("slot word", q, {8'(16*s+2*w+2), 8'(16*s+2*w+1)});
      end
      check("slot", slot[s], {8'(16*s+6), 8'(16*s+5), 8'(16*s+4), 8'(16*s+3),
            8'(16*s+2), 8'(16*s+1)});
    end
    wb(1'b1, IDX_SLOT1_LOW, 16'hffee, 4'h1);
    check("lane", slot[0][15:0], 16'h02ee);
    wb(1'b1, 8'h90, 16'h1234, 4'hf);
    wb(1'b0, 8'h90, 16'h0000, 4'hf);
    check("unmapped", q, 16'h0000);
    wb(1'b1, IDX_MAC_IDENT, 16'hffff, 4'hf);
    wb(1'b0, IDX_MAC_IDENT, 16'h0000, 4'hf);
    check("ident", q, IDENT);
    wb(1'b1, IDX_POLL_CONFIG, 16'h7ff8, 4'hf);
    wb(1'b0, IDX_POLL_CONFIG, 16'h0000, 4'hf);
    check("config", q, 16'h1f00);
    // poll phy 0x0b, divider 1
    wb(1'b1, IDX_IRQ_MASK, 16'h0001, 4'hf);
    wb(1'b1, IDX_POLL_CONFIG, 16'h8b01, 4'hf);
    wait_irq();
    wb(1'b0, IDX_IRQ_STATUS, 16'h0000, 4'hf);
    check("irq status", q, 16'h0003);
    @(posedge mclk);
    check("irq cleared", irq, 1'b0);
    wb(1'b1, IDX_PHY_STATUS, 16'h0000, 4'hf);
    wb(1'b0, IDX_PHY_STATUS, 16'h0000, 4'hf);
    check("phy status", q, 16'hc35a);
    check("frame head", head, {32'hffff_ffff, 4'h6, 5'h0b, 5'h01});
    for (int d = 1; d >= 0; d--) begin
      wb(1'b1, IDX_POLL_CONFIG, {13'h1160, 3'(d)}, 4'hf);
      frame_gap(gap);
      frame_gap(gap);
      check("poll period", gap, 4 * (2 ** (9 - d)));
    end
    // absent phy address: disable first; the first pass drains stale status, a
    // frame still in flight may take the second, the last follows a fresh poll
    wb(1'b1, IDX_POLL_CONFIG, 16'h0000, 4'hf);
    wb(1'b1, IDX_POLL_CONFIG, 16'h8401, 4'hf);
    repeat (3) begin
      wait_irq();
      wb(1'b0, IDX_IRQ_STATUS, 16'h0000, 4'hf);
      @(posedge mclk);
    end
    wb(1'b0, IDX_PHY_STATUS, 16'h0000, 4'hf);
    check("absent phy", q, 16'hffff);
    // ticks faster than a frame are dropped and flagged
    wb(1'b1, IDX_IRQ_MASK, 16'h0004, 4'hf);
    wb(1'b1, IDX_POLL_CONFIG, 16'h8407, 4'hf);
    wait_irq();
    wb(1'b0, IDX_IRQ_STATUS, 16'h0000, 4'hf);
    check("overrun", q & 16'h0004, 16'h0004);
    wb(1'b1, IDX_IRQ_MASK, 16'h0000, 4'hf);
    repeat (40) @(posedge mclk);
    check("masked irq", irq, 1'b0);
    wb(1'b1, IDX_POLL_CONFIG, 16'h0000, 4'hf);
    finish_test();
  end
endmodule // testbench
